// ===== rtl/fcf_flag_gen.v
// near-full / near-empty flag generator with axi4-lite registers
`timescale 1ns/1ps
`include "fcf_defines.vh"

module fcf_flag_gen
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        ce,
   input  wire        write_side_clock,
   input  wire        fill_request_enable,
   input  wire        read_side_clock,
   input  wire        drain_request_enable,
   output reg         near_full_flag,
   output reg         near_empty_flag,
   output reg  [12:0] words_held_count,
   output reg  [11:0] hard_full_offset,
   output reg  [11:0] hard_empty_offset,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);

   // =====================================
   // declarations
   wire        store_mark_sync;
   wire        drain_mark_sync;
   wire        write_rise;
   wire        read_rise;
   reg         count_enable;
   reg  [1:0]  geometry;
   reg  [11:0] nf_thresh;
   reg  [11:0] ne_thresh;
   reg         nf_cond;
   reg         ne_cond;
   reg  [12:0] depth;
   reg  [7:0]  aw_addr_q;
   reg  [31:0] w_data_q;
   reg  [3:0]  w_strb_q;
   reg         aw_held;
   reg         w_held;
   reg         next_aw_held;
   reg         next_w_held;
   reg         next_bvalid;
   reg         next_arready;
   reg         next_rvalid;
   reg  [31:0] read_word;
   reg         read_hit;
   wire        write_hit;
   wire        aw_take;
   wire        w_take;
   wire        ar_take;
   wire        wr_commit;
   wire        clear_hit;
   wire        over_limit;
   wire [12:0] hard_ae_full;

   // =====================================
   // request synchronisers
   fcf_req_sync u_write_sync
   (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .ce             (ce),
      .side_clock     (write_side_clock),
      .request_enable (fill_request_enable),
      .side_rise      (write_rise),
      .request_pulse  (store_mark_sync)
   );

   fcf_req_sync u_read_sync
   (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .ce             (ce),
      .side_clock     (read_side_clock),
      .request_enable (drain_request_enable),
      .side_rise      (read_rise),
      .request_pulse  (drain_mark_sync)
   );

   // =====================================
   // geometry decode
   // only four geometries exist, so the two-bit code covers all of them
   always @*
   begin
      case (geometry)
         `FCF_GEO_4KX4:  depth = `FCF_DEPTH_4K;
         `FCF_GEO_2KX9:  depth = `FCF_DEPTH_2K;
         `FCF_GEO_1KX18: depth = `FCF_DEPTH_1K;
         default:        depth = `FCF_DEPTH_512;
      endcase
   end

   assign hard_ae_full = depth - `FCF_HARD_AE_SUB;
   assign over_limit   = words_held_count > (depth - `FCF_HEADROOM);

   // =====================================
   // words-held counter
   // a request pulse lives one fast cycle, so the count moves at the
   // third fast edge after the side clock edge at the earliest
   assign clear_hit = wr_commit & (aw_addr_q == `FCF_ADDR_CTRL) &
                      w_strb_q[0] & w_data_q[`FCF_CTRL_CLR];

   always @(posedge aclk)
   begin
      if (!aresetn)
         words_held_count <= 13'h0000;
      else if (ce)
      begin
         if (clear_hit)
            words_held_count <= 13'h0000;
         else if (count_enable)
         begin
            case ({store_mark_sync, drain_mark_sync})
               2'h2:
                  if (words_held_count != depth)
                     words_held_count <= words_held_count + 13'h0001;
               2'h1:
                  if (words_held_count != 13'h0000)
                     words_held_count <= words_held_count - 13'h0001;
               default:
                  words_held_count <= words_held_count;
            endcase
         end
      end
   end

   // =====================================
   // threshold compare, flag retiming and hard fifo offsets
   // flags move only on a seen side clock edge, so a stopped side
   // clock freezes its flag just as a real side-clocked flop would
   // no full flag is made here; the hard fifo full flag serves
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         nf_cond           <= 1'h0;
         ne_cond           <= 1'h1;
         near_full_flag    <= 1'h0;
         near_empty_flag   <= 1'h1;
         hard_full_offset  <= `FCF_HARD_AF;
         hard_empty_offset <= 12'h000;
      end
      else if (ce)
      begin
         nf_cond           <= words_held_count >= {1'h0, nf_thresh};
         ne_cond           <= words_held_count <= {1'h0, ne_thresh};
         if (write_rise)
            near_full_flag <= nf_cond;
         if (read_rise)
            near_empty_flag <= ne_cond;
         hard_full_offset  <= `FCF_HARD_AF;
         hard_empty_offset <= hard_ae_full[11:0];
      end
   end

   // =====================================
   // axi4-lite write channel
   assign aw_take   = s_axi_awvalid & s_axi_awready;
   assign w_take    = s_axi_wvalid & s_axi_wready;
   assign wr_commit = aw_held & w_held & ~s_axi_bvalid;

   always @*
   begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_bvalid  = s_axi_bvalid;
      if (aw_take)
         next_aw_held = 1'h1;
      if (w_take)
         next_w_held = 1'h1;
      if (wr_commit)
      begin
         next_aw_held = 1'h0;
         next_w_held  = 1'h0;
         next_bvalid  = 1'h1;
      end
      if (s_axi_bvalid & s_axi_bready)
         next_bvalid = 1'h0;
   end

   assign write_hit = (aw_addr_q == `FCF_ADDR_CTRL) | (aw_addr_q == `FCF_ADDR_NFTH) |
                      (aw_addr_q == `FCF_ADDR_NETH);

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held       <= 1'h0;
         w_held        <= 1'h0;
         aw_addr_q     <= 8'h00;
         w_data_q      <= 32'h00000000;
         w_strb_q      <= 4'h0;
         s_axi_awready <= 1'h0;
         s_axi_wready  <= 1'h0;
         s_axi_bvalid  <= 1'h0;
         s_axi_bresp   <= `FCF_RESP_OKAY;
      end
      else if (ce)
      begin
         if (aw_take)
            aw_addr_q <= s_axi_awaddr;
         if (w_take)
         begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_commit)
            s_axi_bresp <= write_hit ? `FCF_RESP_OKAY : `FCF_RESP_SLVERR;
         aw_held       <= next_aw_held;
         w_held        <= next_w_held;
         s_axi_bvalid  <= next_bvalid;
         s_axi_awready <= ~next_aw_held & ~next_bvalid;
         s_axi_wready  <= ~next_w_held & ~next_bvalid;
      end
   end

   // =====================================
   // control and threshold registers
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count_enable <= `FCF_RST_EN;
         geometry     <= `FCF_RST_GEO;
         nf_thresh    <= `FCF_RST_NFTH;
         ne_thresh    <= `FCF_RST_NETH;
      end
      else if (ce && wr_commit)
      begin
         case (aw_addr_q)
            `FCF_ADDR_CTRL:
               if (w_strb_q[0])
               begin
                  count_enable <= w_data_q[`FCF_CTRL_EN];
                  geometry     <= w_data_q[`FCF_CTRL_GEO_HI:`FCF_CTRL_GEO_LO];
               end
            `FCF_ADDR_NFTH:
            begin
               if (w_strb_q[0])
                  nf_thresh[7:0] <= w_data_q[7:0];
               if (w_strb_q[1])
                  nf_thresh[11:8] <= w_data_q[11:8];
            end
            `FCF_ADDR_NETH:
            begin
               if (w_strb_q[0])
                  ne_thresh[7:0] <= w_data_q[7:0];
               if (w_strb_q[1])
                  ne_thresh[11:8] <= w_data_q[11:8];
            end
            default:
               count_enable <= count_enable;
         endcase
      end
   end

   // =====================================
   // axi4-lite read channel
   assign ar_take = s_axi_arvalid & s_axi_arready;

   always @*
   begin
      read_word = 32'h00000000;
      read_hit  = 1'h1;
      case (s_axi_araddr)
         `FCF_ADDR_CTRL:
         begin
            read_word[`FCF_CTRL_EN] = count_enable;
            read_word[`FCF_CTRL_GEO_HI:`FCF_CTRL_GEO_LO] = geometry;
         end
         `FCF_ADDR_NFTH:
            read_word[11:0] = nf_thresh;
         `FCF_ADDR_NETH:
            read_word[11:0] = ne_thresh;
         `FCF_ADDR_STAT:
         begin
            read_word[12:0]          = words_held_count;
            read_word[`FCF_STAT_NFC] = nf_cond;
            read_word[`FCF_STAT_NEC] = ne_cond;
            read_word[`FCF_STAT_NFF] = near_full_flag;
            read_word[`FCF_STAT_NEF] = near_empty_flag;
            read_word[`FCF_STAT_OVL] = over_limit;
         end
         `FCF_ADDR_HARD:
         begin
            read_word[11:0]  = hard_full_offset;
            read_word[27:16] = hard_empty_offset;
         end
         default:
            read_hit = 1'h0;
      endcase
   end

   always @*
   begin
      next_rvalid = s_axi_rvalid;
      if (ar_take)
         next_rvalid = 1'h1;
      else if (s_axi_rvalid & s_axi_rready)
         next_rvalid = 1'h0;
      next_arready = ~next_rvalid;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'h0;
         s_axi_rvalid  <= 1'h0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `FCF_RESP_OKAY;
      end
      else if (ce)
      begin
         if (ar_take)
         begin
            s_axi_rdata <= read_word;
            s_axi_rresp <= read_hit ? `FCF_RESP_OKAY : `FCF_RESP_SLVERR;
         end
         s_axi_rvalid  <= next_rvalid;
         s_axi_arready <= next_arready;
      end
   end

endmodule

// ===== rtl/fcf_defines.vh
// constants for the fast-clock flag generator
`ifndef FCF_DEFINES_VH
`define FCF_DEFINES_VH

// =====================================
// register byte offsets
`define FCF_ADDR_CTRL   8'h00
`define FCF_ADDR_NFTH   8'h04
`define FCF_ADDR_NETH   8'h08
`define FCF_ADDR_STAT   8'h0c
`define FCF_ADDR_HARD   8'h10

// =====================================
// control fields
`define FCF_CTRL_EN     0
`define FCF_CTRL_CLR    1
`define FCF_CTRL_GEO_LO 4
`define FCF_CTRL_GEO_HI 5

// =====================================
// status fields
`define FCF_STAT_NFC    16
`define FCF_STAT_NEC    17
`define FCF_STAT_NFF    18
`define FCF_STAT_NEF    19
`define FCF_STAT_OVL    20

// =====================================
// geometry codes and depths
`define FCF_GEO_4KX4    2'h0
`define FCF_GEO_2KX9    2'h1
`define FCF_GEO_1KX18   2'h2
`define FCF_GEO_512X36  2'h3
`define FCF_DEPTH_4K    13'h1000
`define FCF_DEPTH_2K    13'h0800
`define FCF_DEPTH_1K    13'h0400
`define FCF_DEPTH_512   13'h0200
`define FCF_CNT_W       13
`define FCF_TH_W        12

// =====================================
// reset values and fixed figures
`define FCF_RST_EN      1'h1
`define FCF_RST_GEO     2'h3
`define FCF_RST_NFTH    12'h1f0
`define FCF_RST_NETH    12'h010
`define FCF_HARD_AF     12'h001
`define FCF_HARD_AE_SUB 13'h0002
`define FCF_HEADROOM    13'h0003
`define FCF_RESP_OKAY   2'h0
`define FCF_RESP_SLVERR 2'h2

`endif

// ===== rtl/fcf_req_sync.v
// side-clock and request synchroniser into the fast domain
`timescale 1ns/1ps

module fcf_req_sync
(
   input  wire aclk,
   input  wire aresetn,
   input  wire ce,
   input  wire side_clock,
   input  wire request_enable,
   output wire side_rise,
   output wire request_pulse
);

   // =====================================
   // two-stage synchronisers
   reg clk_meta;
   reg clk_sync;
   reg clk_prev;
   reg en_meta;
   reg en_sync;

   // first stage may go metastable; only the second stage reads it
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         clk_meta <= 1'h0;
         clk_sync <= 1'h0;
         clk_prev <= 1'h0;
         en_meta  <= 1'h0;
         en_sync  <= 1'h0;
      end
      else if (ce)
      begin
         clk_meta <= side_clock;
         clk_sync <= clk_meta;
         clk_prev <= clk_sync;
         en_meta  <= request_enable;
         en_sync  <= en_meta;
      end
   end

   // =====================================
   // edge detect on the synchronised side clock
   assign side_rise     = clk_sync & ~clk_prev;
   assign request_pulse = side_rise & en_sync;

endmodule

// ===== testbench/fcf_side_model.sv
// side clock and request model for one far-side port
`timescale 1ns/1ps

// =====================================
// side port model
module fcf_side_model
#(
   parameter real HALF = 160.0
)
(
   output reg side_clock,
   output reg req_en
);
   initial
   begin
      side_clock = 1'b0;
      req_en = 1'b0;
   end

   // clock only runs inside a burst, stands low between bursts
   // half period over three fast periods, unrelated phase
   task burst(input integer n_on, input integer n_off);
      integer i;
      begin
         for (i = 0; i < n_on + n_off; i = i + 1)
         begin
            req_en = (i < n_on);
            #(HALF) side_clock = 1'b1;
            #(HALF) side_clock = 1'b0;
         end
         req_en = 1'b0;
      end
   endtask
endmodule

// ===== testbench/fcf_flag_gen_chk.sv
// assertion checker for the fast-clock flag generator
`timescale 1ns/1ps

// =====================================
// checker
module fcf_chk
(
   input wire        aclk,
   input wire        aresetn,
   input wire        write_side_clock,
   input wire        read_side_clock,
   input wire        near_full_flag,
   input wire        near_empty_flag,
   input wire [12:0] words_held_count,
   input wire [11:0] hard_full_offset,
   input wire [11:0] hard_empty_offset,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // cycles since a side clock rise was first seen
   reg       wq;
   reg       rq;
   reg [2:0] w_age;
   reg [2:0] r_age;
   always @(posedge aclk)
   begin
      wq <= write_side_clock;
      rq <= read_side_clock;
      if (!aresetn)
      begin
         w_age <= 3'h7;
         r_age <= 3'h7;
      end
      else
      begin
         w_age <= (write_side_clock && !wq) ? 3'h0 : ((w_age == 3'h7) ? 3'h7 : w_age + 3'h1);
         r_age <= (read_side_clock && !rq) ? 3'h0 : ((r_age == 3'h7) ? 3'h7 : r_age + 3'h1);
      end
   end

   sequence s_wtake;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_bresp;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence

   property p_b_lat;
      s_wtake |=> s_bresp;
   endproperty
   property p_r_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_hard_full;
      hard_full_offset == 12'h001;
   endproperty
   property p_empty_off;
      $past(aresetn) |-> hard_empty_offset inside {12'hffe, 12'h7fe, 12'h3fe, 12'h1fe};
   endproperty
   property p_cnt_rng;
      words_held_count <= 13'h1000;
   endproperty
   property p_cnt_step;
      words_held_count != $past(words_held_count) |-> words_held_count == 13'h0
         || words_held_count == $past(words_held_count) + 13'h1
         || words_held_count == $past(words_held_count) - 13'h1;
   endproperty
   property p_nf_upd;
      $changed(near_full_flag) |-> w_age <= 3'h5;
   endproperty
   property p_ne_upd;
      $changed(near_empty_flag) |-> r_age <= 3'h5;
   endproperty

   a_b_lat: assert property (p_b_lat) else $error("write response late or early");
   a_r_lat: assert property (p_r_lat) else $error("read response late");
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   a_hard_full: assert property (p_hard_full) else $error("bad full offset");
   a_empty_off: assert property (p_empty_off) else $error("bad empty offset");
   a_cnt_rng: assert property (p_cnt_rng) else $error("count out of range");
   a_cnt_step: assert property (p_cnt_step) else $error("count jumped");
   a_nf_upd: assert property (p_nf_upd) else $error("near full off write clock");
   a_ne_upd: assert property (p_ne_upd) else $error("near empty off read clock");
endmodule

bind fcf_flag_gen fcf_chk CHK (.aclk, .aresetn, .write_side_clock, .read_side_clock,
   .near_full_flag, .near_empty_flag, .words_held_count, .hard_full_offset,
   .hard_empty_offset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// ===== testbench/testbench.sv
// self-checking bench for the fast-clock flag generator
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count = cmp_count + 1; if ((g) !== (e)) begin \
   mismatches = mismatches + 1; $display("ERROR %0s expected %0h seen %0h", nm, e, g); end end

module testbench;
   reg         aclk;
   reg         aresetn;
   reg         ce;
   reg  [7:0]  awaddr;
   reg  [7:0]  araddr;
   reg  [31:0] wdata;
   reg         awvalid, wvalid, bready, arvalid, rready;
   wire        awready, wready, bvalid, arready, rvalid;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire        wsc, wen, rsc, ren, nf, ne;
   wire [12:0] cnt;
   wire [11:0] hoff, eoff;
   integer     mismatches, cmp_count, mcount, g, nw, nr;
   reg  [12:0] ecnt, nfth, neth, ehard;
   reg  [31:0] d;
   reg  [1:0]  r;

   fcf_side_model #(.HALF(160.0)) WSIDE (.side_clock(wsc), .req_en(wen));
   fcf_side_model #(.HALF(185.0)) RSIDE (.side_clock(rsc), .req_en(ren));

   fcf_flag_gen DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .write_side_clock(wsc),
      .fill_request_enable(wen), .read_side_clock(rsc), .drain_request_enable(ren),
      .near_full_flag(nf), .near_empty_flag(ne), .words_held_count(cnt),
      .hard_full_offset(hoff), .hard_empty_offset(eoff), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   // fast clock runs from time zero, never stops
   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   task end_of_test;
      begin
         $display("compares %0d mismatches %0d", cmp_count, mismatches);
         if (mismatches == 0 && cmp_count > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   // ready sampled mid-cycle is what the next rising edge sees
   task axi_wr(input [7:0] a, input [31:0] dd, output [1:0] rr);
      reg ra, rw, rb;
      begin
         awaddr <= a;
         wdata <= dd;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         rb = 1'b0;
         while (!rb)
         begin
            @(negedge aclk);
            ra = awready;
            rw = wready;
            rb = (bvalid === 1'b1);
            rr = bresp;
            @(posedge aclk);
            if (ra === 1'b1) awvalid <= 1'b0;
            if (rw === 1'b1) wvalid <= 1'b0;
         end
         bready <= 1'b0;
         @(posedge aclk);
      end
   endtask

   task axi_rd(input [7:0] a, output [31:0] dd, output [1:0] rr);
      reg ra, rb;
      begin
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         rb = 1'b0;
         while (!rb)
         begin
            @(negedge aclk);
            ra = arready;
            rb = (rvalid === 1'b1);
            dd = rdata;
            rr = rresp;
            @(posedge aclk);
            if (ra === 1'b1) arvalid <= 1'b0;
         end
         rready <= 1'b0;
         @(posedge aclk);
      end
   endtask

   // both sides burst at once, then idle rises let the flags retime
   task traffic(input integer w, input integer rd);
      begin
         fork
            WSIDE.burst(w, 0);
            RSIDE.burst(rd, 0);
         join
         fork
            WSIDE.burst(0, 2);
            RSIDE.burst(0, 2);
         join
         @(posedge aclk);
         mcount = mcount + w - rd;
         ecnt = mcount;
         `CHK("count", ecnt, cnt);
         `CHK("near_full", (ecnt >= nfth), nf);
         `CHK("near_empty", (ecnt <= neth), ne);
         axi_rd(8'h0c, d, r);
         `CHK("stat_count", ecnt, d[12:0]);
      end
   endtask

   initial
   begin
      aresetn = 1'b0;
      ce = 1'b1;
      {awaddr, araddr, wdata} = 48'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {mismatches, cmp_count, mcount} = 96'h0;
      r = $urandom(66809);
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(8'h00, d, r);
      `CHK("ctrl_rst", 32'h00000031, d);
      axi_rd(8'h04, d, r);
      `CHK("nfth_rst", 32'h000001f0, d);
      axi_rd(8'h08, d, r);
      `CHK("neth_rst", 32'h00000010, d);
      axi_rd(8'h10, d, r);
      `CHK("hard_rst", 32'h01fe0001, d);
      axi_rd(8'h14, d, r);
      `CHK("unmapped_rd", 34'h200000000, {r, d});
      axi_wr(8'h0c, 32'h00000005, r);
      `CHK("ro_wr", 2'h2, r);
      $display("test registers done");
      for (g = 0; g < 4; g = g + 1)
      begin
         axi_wr(8'h00, (g << 4) | 32'h1, r);
         ehard = (13'h1000 >> g) - 13'h2;
         axi_rd(8'h10, d, r);
         `CHK("hard_reg", {4'h0, ehard[11:0], 16'h0001}, d);
         `CHK("hard_port", ehard[11:0], eoff);
         `CHK("full_port", 12'h001, hoff);
      end
      $display("test geometry done");
      axi_wr(8'h04, 32'h0000000a, r);
      nfth = 13'h00a;
      axi_wr(8'h08, 32'h00000004, r);
      neth = 13'h004;
      repeat (10)
      begin
         nw = $urandom % 7;
         nr = $urandom % (mcount + 1);
         traffic(nw, (nr > 6) ? 6 : nr);
      end
      $display("test random traffic done");
      traffic(509 - mcount, 0);
      `CHK("headroom", 1'b0, d[20]);
      // counting switched off: reads must leave the count where it is
      axi_wr(8'h00, 32'h00000030, r);
      mcount = mcount + 2;
      traffic(0, 2);
      $display("test count hold done");
      axi_wr(8'h00, 32'h00000033, r);
      mcount = 0;
      traffic(1, 0);
      $display("test fill and clear done");
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK("rst_count", 13'h0000, cnt);
      `CHK("rst_near_full", 1'b0, nf);
      `CHK("rst_near_empty", 1'b1, ne);
      axi_rd(8'h00, d, r);
      `CHK("rst_ctrl", 32'h00000031, d);
      axi_rd(8'h10, d, r);
      `CHK("rst_hard", 32'h01fe0001, d);
      $display("test mid-run reset done");
      end_of_test;
   end

   initial
   begin
      repeat (60000) @(posedge aclk);
      mismatches = mismatches + 1;
      end_of_test;
   end
endmodule
